/* include/sats_pkg.sv */
// Constants and types shared by the converter end and the host end of the serial link
// Behaviour
// RULE_01: Sample from third to tenth shift-clock fall
// RULE_02: Full cycle within conversion time plus ten clocks
// RULE_03: Select change valid only after filter time; the code filters select falls only, a synced rise acts at once
// RULE_04: Shift clock ignored until select setup passes
// RULE_05: Select high stops shift-clock response promptly
// RULE_06: Host waits for conversion end before clocking
// RULE_07: Select low soon after tenth fall aborts
// RULE_08: Result saturates at all ones or zeros
// RULE_09: Select low drives data out with MSB
// RULE_10: Select high floats data out quickly
// RULE_11: Select-framed transfers of 11 to 16 clocks
// RULE_12: Select held low means 16-clock transfers
// RULE_13: Works whether transfer ends before or after conversion
// RULE_14: Host gives rising edge soon after tenth fall
// RULE_15: Result shifted MSB first on falling edges
// RULE_16: Conversion starts itself when sampling ends
package sats_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int unsigned RES_W       = 10;                 // Result width
  localparam logic [9:0]  CODE_MAX    = 10'h3FF;            // Saturated high code
  localparam logic [9:0]  CODE_MIN    = 10'h000;            // Saturated low code
  localparam logic [4:0]  EDGE_SAMPLE = 5'h03;              // Fall that opens sampling
  localparam logic [4:0]  EDGE_HOLD   = 5'h0A;              // Fall that closes sampling
  localparam logic [4:0]  LEN_FREE    = 5'h10;              // Transfer length without select

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_MHZ      = 100;               // System clock rate
  localparam int unsigned T_FILT_NS    = 1425;              // Select filter time
  localparam int unsigned T_CONV_NS    = 21000;             // Conversion time
  localparam int unsigned T_ABORT_NS   = 9000;              // Abort window after tenth fall
  localparam int unsigned T_EN_NS      = 1300;              // Select low to MSB driven
  localparam int unsigned T_DIS_NS     = 180;               // Select high to float
  localparam int unsigned T_RISE_NS    = 9500;              // Host rising edge deadline
  localparam int unsigned T_SCK_HALF_NS = 240;              // Host shift clock half period
  // Least times round up, longest times round down
  localparam int unsigned FILT_CYC  = (T_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC  = (T_CONV_NS * CLK_MHZ) / 1000 - 100;
  localparam int unsigned ABORT_CYC = (T_ABORT_NS * CLK_MHZ) / 1000;
  localparam int unsigned EN_CYC    = (T_EN_NS * CLK_MHZ) / 1000;
  localparam int unsigned DIS_CYC   = (T_DIS_NS * CLK_MHZ) / 1000;
  localparam int unsigned RISE_CYC  = (T_RISE_NS * CLK_MHZ) / 1000;
  localparam int unsigned HALF_CYC  = (T_SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] FILT_CNT  = 12'(FILT_CYC);
  localparam logic [11:0] CONV_CNT  = 12'(CONV_CYC);
  localparam logic [11:0] ABORT_CNT = 12'(ABORT_CYC);
  localparam logic [11:0] HALF_CNT  = 12'(HALF_CYC);

  // ********************************************************
  // Converter sequencer states, Gray along the usual path
  // ********************************************************
  typedef enum logic [2:0] {
    SATS_IDLE  = 3'h0,
    SATS_SHIFT = 3'h1,
    SATS_CONV  = 3'h3,
    SATS_DONE  = 3'h2
  } sats_state_t;

  // Host states, Gray along the usual path except END back to IDLE
  typedef enum logic [2:0] {
    SATS_H_IDLE  = 3'h0,
    SATS_H_SETUP = 3'h1,
    SATS_H_CLK   = 3'h3,
    SATS_H_WAIT  = 3'h2,
    SATS_H_END   = 3'h6
  } sats_hstate_t;

endpackage

/* include/sats_if.sv */
// Three-wire serial link between converter and host
`timescale 1ns/100ps
interface sats_if;
  logic sel_n;        // Active-low select, from host
  logic sck;          // Shift clock, from host
  logic sdo_o;        // Data out value, from converter
  logic sdo_oe;       // Data out enable, high while converter drives
  modport conv (input sel_n, input sck, output sdo_o, output sdo_oe);
  modport host (output sel_n, output sck, input sdo_o, input sdo_oe);
endinterface

/* hdl/sats_conv.sv */
// Converter end: select filter, shift-out, sampling window and conversion timer
`timescale 1ns/100ps
module sats_conv
  import sats_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Link
  sats_if.conv                       link,
  // Analog front end, as digital stand-ins
  input  wire logic [sats_pkg::RES_W-1:0] ain_code,
  input  wire logic                  ain_over,
  input  wire logic                  ain_under,
  // Status
  output logic                       sampling,
  output logic                       converting,
  output logic                       conv_abort,
  output logic [sats_pkg::RES_W-1:0] result
);
  import sats_pkg::*;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [1:0] sel_sync_q;     // Select, two flops
  logic [1:0] sck_sync_q;     // Shift clock, two flops
  logic       sck_prev_q;     // Previous synced clock for edges
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[0], link.sel_n};
      sck_sync_q <= {sck_sync_q[0], link.sck};
      sck_prev_q <= sck_sync_q[1];
    end
  end
  wire sel_s    = sel_sync_q[1];
  wire sck_fall = sck_prev_q & ~sck_sync_q[1];
  wire sck_rise = ~sck_prev_q & sck_sync_q[1];

  // ********************************************************
  // Select filter
  // ********************************************************
  // A new low select level counts only once held for the filter time, so
  // glitches on a long select trace never start a transfer; a synced select rise stops one at once
  logic        sel_f_q;       // Filtered select, active low
  logic [11:0] filt_q;        // Hold counter
  wire         sel_diff = sel_s ^ sel_f_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_f_q <= 1'b1;
      filt_q  <= 12'h000;
    end
    else if (!sel_diff)
      filt_q <= 12'h000;
    else if (filt_q >= FILT_CNT - 12'h001)
    begin
      sel_f_q <= sel_s;  // RULE_03
      filt_q  <= 12'h000;
    end
    else
      filt_q <= filt_q + 12'h001;
  end
  // Shift clock heard only while filtered select is low
  wire sel_on   = ~sel_f_q & ~sel_s;  // RULE_04 RULE_05
  wire sel_fall = sel_f_q & sel_diff & (filt_q >= FILT_CNT - 12'h001) & ~sel_s;
  wire sel_rise = ~sel_f_q & sel_s;
  // First cycle of a synced select fall, before the filter runs out; the
  // output turns on here so the MSB shows inside its enable time, while
  // the shift clock stays ignored until the filter has passed
  wire sel_drop = sel_f_q & ~sel_s & (filt_q == 12'h000);  // RULE_09

  // ********************************************************
  // Sequencer
  // ********************************************************
  sats_state_t         st_q;         // Sequencer state
  logic [4:0]          fall_q;       // Falls counted in the transfer
  logic [11:0]         tmr_q;        // Conversion and abort timer
  logic [RES_W-1:0]    shreg_q;      // Outgoing result bits
  logic [RES_W-1:0]    res_q;        // Last finished result
  logic [RES_W-1:0]    held_q;       // Input caught at end of sampling
  logic                samp_q;       // Sampling window
  logic                abort_q;      // Abort pulse
  logic                oe_q;         // Data out enable
  logic                busy_q;       // Conversion running

  // Saturated code of the held input
  wire [RES_W-1:0] sat_code = ain_over ? CODE_MAX : (ain_under ? CODE_MIN : ain_code);  // RULE_08
  wire tenth     = sck_fall & sel_on & (fall_q == EDGE_HOLD - 5'h01);
  wire third     = sck_fall & sel_on & (fall_q == EDGE_SAMPLE - 5'h01);
  wire conv_end  = busy_q & (tmr_q == 12'h000);
  // Select dropping soon after the tenth fall kills the conversion
  wire abort_hit = busy_q & sel_fall & (tmr_q > CONV_CNT - ABORT_CNT);  // RULE_07
  // Without select, the 16th fall closes a transfer
  wire len_end   = sck_fall & sel_on & (fall_q == LEN_FREE - 5'h01);  // RULE_12

  // Main state process
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= SATS_IDLE;
      fall_q <= 5'h00;
      samp_q <= 1'b0;
      busy_q <= 1'b0;
      tmr_q  <= 12'h000;
    end
    else
    begin
      // Conversion timer runs on the system clock, not the shift clock
      if (tenth)
      begin
        busy_q <= 1'b1;     // RULE_16
        tmr_q  <= CONV_CNT; // RULE_02
      end
      else if (abort_hit || conv_end)
        busy_q <= 1'b0;
      else if (busy_q)
        tmr_q <= tmr_q - 12'h001;
      // Sampling window
      if (third)
        samp_q <= 1'b1;     // RULE_01
      else if (tenth || sel_rise)
        samp_q <= 1'b0;
      // Falls counted per transfer, any length 11..16 accepted
      if (sel_rise || sel_fall || len_end)
        fall_q <= 5'h00;    // RULE_11
      else if (sck_fall && sel_on)
        fall_q <= fall_q + 5'h01;
      case (st_q)
        SATS_IDLE:  if (sel_on) st_q <= SATS_SHIFT;
        SATS_SHIFT: if (tenth) st_q <= SATS_CONV;
                    else if (sel_rise) st_q <= SATS_IDLE;
        SATS_CONV:  if (abort_hit || conv_end) st_q <= SATS_DONE;  // RULE_13
        SATS_DONE:  st_q <= SATS_IDLE;
        default:    st_q <= SATS_IDLE;
      endcase
    end
  end

  // Result path and data out
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      shreg_q <= CODE_MIN;
      res_q   <= CODE_MIN;
      held_q  <= CODE_MIN;
      oe_q    <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      abort_q <= abort_hit;
      if (tenth)
        held_q <= sat_code;
      if (conv_end)
        res_q <= held_q;
      // Load at select fall or at a free-running frame start
      if (sel_drop || (len_end && !sel_rise))
        shreg_q <= conv_end ? held_q : res_q;  // RULE_09
      else if (sck_fall && sel_on)
        shreg_q <= {shreg_q[RES_W-2:0], 1'b0};  // RULE_15
      // Float within a few cycles of select rising
      if (sel_s)
        oe_q <= 1'b0;       // RULE_10
      else if (sel_drop)
        oe_q <= 1'b1;       // RULE_09
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign link.sdo_o  = shreg_q[RES_W-1];
  assign link.sdo_oe = oe_q;
  assign sampling    = samp_q;
  assign converting  = busy_q;
  assign conv_abort  = abort_q;
  assign result      = res_q;
  wire unused_rise   = sck_rise;  // Rising edges carry no action here

endmodule

/* hdl/sats_host.sv */
// Host end: frames transfers with select, makes the shift clock, collects the result
`timescale 1ns/100ps
module sats_host
  import sats_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Link
  sats_if.host                       link,
  // User side
  input  wire logic                  start,
  input  wire logic [4:0]            xfer_len,
  output logic                       busy,
  output logic                       done,
  output logic [sats_pkg::RES_W-1:0] rx_data
);
  import sats_pkg::*;

  // ********************************************************
  // Data input synchroniser
  // ********************************************************
  logic [1:0] sdo_sync_q;     // Data out, two flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sdo_sync_q <= 2'h0;
    else
      sdo_sync_q <= {sdo_sync_q[0], link.sdo_o};
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  sats_hstate_t       st_q;     // Host state
  logic [11:0]        cnt_q;    // Setup, half period and wait counter
  logic [4:0]         edge_q;   // Clocks issued
  logic [4:0]         len_q;    // Clocks wanted, clamped to 11..16
  logic               sel_q;    // Select, active low
  logic               sck_q;    // Shift clock
  logic [RES_W-1:0]   rx_q;     // Collected bits
  logic               done_q;   // Done pulse
  logic               busy_q;   // Transfer under way

  wire [4:0] len_c   = (xfer_len < 5'h0B) ? 5'h0B : ((xfer_len > 5'h10) ? 5'h10 : xfer_len);
  wire       cnt_end = (cnt_q == 12'h000);
  // Clocks run back to back so a rising edge follows the tenth fall fast
  wire       last    = (edge_q == len_q);  // RULE_14

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= SATS_H_IDLE;
      cnt_q  <= 12'h000;
      edge_q <= 5'h00;
      len_q  <= LEN_FREE;
      sel_q  <= 1'b1;
      sck_q  <= 1'b0;
      rx_q   <= CODE_MIN;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!cnt_end)
        cnt_q <= cnt_q - 12'h001;
      case (st_q)
        SATS_H_IDLE:
          if (start)
          begin
            len_q <= len_c;                 // RULE_11
            sel_q <= 1'b0;
            cnt_q <= FILT_CNT + HALF_CNT;   // RULE_04
            edge_q <= 5'h00;
            busy_q <= 1'b1;
            st_q  <= SATS_H_SETUP;
          end
        SATS_H_SETUP:
          if (cnt_end) st_q <= SATS_H_CLK;
        SATS_H_CLK:
          if (cnt_end)
          begin
            cnt_q <= HALF_CNT;
            if (!sck_q)
            begin
              sck_q <= 1'b1;
              // Capture bit on the rising edge, half a period before its falling edge
              if (edge_q < 5'h0A) rx_q <= {rx_q[RES_W-2:0], sdo_sync_q[1]};
            end
            else
            begin
              sck_q  <= 1'b0;
              edge_q <= edge_q + 5'h01;
              if (edge_q + 5'h01 == len_q) st_q <= SATS_H_WAIT;
            end
          end
        SATS_H_WAIT:
          if (cnt_end && last)
          begin
            sel_q <= 1'b1;
            cnt_q <= CONV_CNT + FILT_CNT;   // RULE_06
            st_q  <= SATS_H_END;
          end
        SATS_H_END:
          if (cnt_end)
          begin
            done_q <= 1'b1;
            busy_q <= 1'b0;
            st_q   <= SATS_H_IDLE;
          end
        default: st_q <= SATS_H_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign link.sel_n = sel_q;
  assign link.sck   = sck_q;
  assign busy       = busy_q;
  assign done       = done_q;
  assign rx_data    = rx_q;

endmodule

/* verification/sats_props.sv */
// Concurrent checks on the serial link between converter and host ends
`timescale 1ns/100ps
module sats_props
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link wires
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  // Converter status
  input wire logic sampling,
  input wire logic converting
);
  import sats_pkg::*;

  // ********************************************************
  // Helper counters
  // ********************************************************
  logic [11:0] hi_q, hi_d;   // Cycles with select high, saturating
  logic [11:0] lo_q, lo_d;   // Cycles with select low, saturating
  logic [11:0] cv_q, cv_d;   // Cycles spent converting
  logic [4:0]  fl_q, fl_d;   // Shift-clock falls inside the frame
  logic        sck_q;        // Shift clock one cycle back

  // Saturation keeps a long idle from wrapping round to zero
  assign hi_d = sel_n ? hi_q + {11'h000, ~&hi_q} : 12'h000;
  assign lo_d = sel_n ? 12'h000 : lo_q + {11'h000, ~&lo_q};
  assign cv_d = converting ? cv_q + 12'h001 : 12'h000;
  assign fl_d = sel_n ? 5'h00 : fl_q + {4'h0, sck_q & ~sck};

  // Counters clear with reset so no stale count leaks into a new run
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      {hi_q, lo_q, cv_q, fl_q, sck_q} <= '0;
    else
      {hi_q, lo_q, cv_q, fl_q, sck_q} <= {hi_d, lo_d, cv_d, fl_d, sck};
  end

  // ********************************************************
  // Properties
  // ********************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Select edges open and close a frame
  sequence s_sel_fall;
    $fell(sel_n);
  endsequence
  sequence s_sel_rise;
    $rose(sel_n);
  endsequence

  AST_FLOAT_FAST: assert property (s_sel_rise |-> ##[0:18] !sdo_oe)
    else $error("data out still driven after select rose");
  AST_FLOAT_IDLE: assert property ((hi_q > 12'h012) |-> !sdo_oe)
    else $error("data out driven while select idle");
  AST_FILTER: assert property ($rose(sampling) |-> (lo_q >= FILT_CNT))
    else $error("shift clock answered before select filter time");
  AST_ENABLE: assert property (s_sel_fall |-> ##[1:130] (sdo_oe || sel_n))
    else $error("data out not enabled after select fell");
  AST_SAMPLE_ON: assert property ($rose(sampling) |-> (fl_q == EDGE_SAMPLE))
    else $error("sampling opened on wrong shift-clock fall");
  AST_SAMPLE_OFF: assert property ($fell(sampling) |-> (fl_q == EDGE_HOLD))
    else $error("sampling closed on wrong shift-clock fall");
  AST_IDLE_SCK: assert property ((hi_q > 12'h096) |-> !sampling)
    else $error("shift clock still answered after select rose");
  AST_CONV_START: assert property ($fell(sampling) |-> ##[0:4] converting)
    else $error("conversion did not follow sampling");
  AST_CONV_TIME: assert property (converting |-> (cv_q < 12'h834))
    else $error("conversion ran past its time");
  AST_DATA_HOLD: assert property ((sdo_oe && sck && sck_q) |-> $stable(sdo_o))
    else $error("data out changed while shift clock high");
  COV_FRAME: cover property (s_sel_fall ##[1:160] sdo_oe);
endmodule

/* verification/testbench.sv */
// Self-checking bench joining converter and host ends over one link
`timescale 1ns/100ps
module testbench;
  import sats_pkg::*;

  // ********************************************************
  // Signals
  // ********************************************************
  logic       sys_clk, rst, start, ain_over, ain_under;  // Clock, reset, controls
  logic [4:0] xfer_len;                                  // Requested length
  logic [9:0] ain_code, result, rx_data, exp_res;        // Codes and expectation
  logic       busy, done, sampling, converting;          // Status
  logic       conv_abort;                                // Abort pulse
  logic       sck_l, sel_l;                              // Link wires one cycle back
  logic [9:0] q_rx[$], q_len[$], q_res[$];               // Notes of expected results
  int         mismatches, tests_run, cyc, seed, falls, n;
  int         aborts;                                    // Abort pulses seen

  sats_if link();

  sats_conv u_sats_conv (.sys_clk(sys_clk), .rst(rst), .link(link), .ain_code(ain_code),
    .ain_over(ain_over), .ain_under(ain_under), .sampling(sampling),
    .converting(converting), .conv_abort(conv_abort), .result(result));
  sats_host u_sats_host (.sys_clk(sys_clk), .rst(rst), .link(link), .start(start),
    .xfer_len(xfer_len), .busy(busy), .done(done), .rx_data(rx_data));
  sats_props u_sats_props (.sys_clk(sys_clk), .rst(rst), .sel_n(link.sel_n),
    .sck(link.sck), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .sampling(sampling),
    .converting(converting));

  // ********************************************************
  // Checking and closing
  // ********************************************************
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One framed transfer; the code read back is the one converted last time
  task automatic xfer(input logic [4:0] len, input logic [1:0] sat);
    logic [9:0] code;
    code = 10'($random(seed));
    q_rx.push_back(exp_res);
    // Lengths outside 11..16 are clamped by the host
    q_len.push_back(len < 5'h0B ? 10'h00B : (len > 5'h10 ? 10'h010 : {5'h00, len}));
    exp_res = sat[1] ? CODE_MAX : (sat[0] ? CODE_MIN : code);
    q_res.push_back(exp_res);
    @(posedge sys_clk);
    start <= 1'b1;
    xfer_len <= len;
    ain_code <= code;
    ain_over <= sat[1];
    ain_under <= sat[0];
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    check("busy", {9'h000, busy}, 10'h001);
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    // A transfer that never finishes counts against the run
    if (done !== 1'b1)
      mismatches++;
    check("busy", {9'h000, busy}, 10'h000);
  endtask

  // ********************************************************
  // Clock, watchdog and monitor
  // ********************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Ten transfers take about 30200 cycles; the ceiling leaves room
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      test_done();
    end
  end

  // Watches the user side and the wires, takes the oldest note per result
  always @(posedge sys_clk)
  begin
    if (conv_abort === 1'b1)
      aborts++;
    if (done === 1'b1)
    begin
      check("rx_data", rx_data, q_rx.pop_front());
      check("result", result, q_res.pop_front());
      // Host waits out every conversion, so none may be cut short
      check("conv_abort count", 10'(aborts), 10'h000);
    end
    if (sck_l === 1'b1 && link.sck === 1'b0)
      falls++;
    if (sel_l === 1'b0 && link.sel_n === 1'b1)
    begin
      check("sck falls", 10'(falls), q_len.pop_front());
      falls = 0;
    end
    sck_l <= link.sck;
    sel_l <= link.sel_n;
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    seed = 32'hE2E1;
    rst = 1'b1;
    start = 1'b0;
    xfer_len = 5'h10;
    ain_code = 10'h000;
    ain_over = 1'b0;
    ain_under = 1'b0;
    exp_res = 10'h000;   // Result register clears at reset
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Every length 11..16, two clamped lengths, then both saturations
    for (int i = 0; i < 10; i++)
      xfer(i < 6 ? 5'(11 + i) : (i == 6 ? 5'h05 : 5'h14), {i == 7, i == 8});
    test_done();
  end
endmodule
